// *** core/cprs_pkg.sv ***
// Shared constants, types and helpers for the CPU programmer register set
package cprs_pkg;

   // Values after reset
   localparam logic [15:0] STACK_RESET = 16'h00FF;
   localparam logic [7:0] IDX_HI_RESET = 8'h00;
   // Low byte loaded into the stack pointer by reset_stack_low
   localparam logic [7:0] RESET_STACK_LOW_BYTE = 8'hFF;
   // High byte of every direct-mode address
   localparam logic [7:0] DIR_PAGE = 8'h00;
   // Bytes stacked per call and per interrupt entry
   localparam logic [2:0] CALL_BYTES = 3'h2;
   localparam logic [2:0] INTR_BYTES = 3'h5;
   localparam logic [2:0] ONE_BYTE = 3'h1;

   // Operations offered on the command port
   typedef enum logic [3:0] {
      CMD_NOP = 4'h0,
      CMD_LDA = 4'h1,
      CMD_LDX = 4'h2,
      CMD_LDHX = 4'h3,
      CMD_LDSP = 4'h4,
      CMD_XOP = 4'h5,
      CMD_MUL = 4'h6,
      CMD_DIV = 4'h7,
      CMD_ADD_IMMEDIATE_TO_STACK = 4'h8,
      CMD_RESET_STACK_LOW = 4'h9,
      CMD_EA = 4'hA,
      CMD_BRA = 4'hB,
      CMD_PSHA = 4'hC,
      CMD_PULA = 4'hD,
      CMD_CALL = 4'hE,
      CMD_INTR = 4'hF
   } cprs_cmd_t;

   // Unary operations on the low index byte
   typedef enum logic [3:0] {
      XOP_CLR = 4'h0,
      XOP_INC = 4'h1,
      XOP_DEC = 4'h2,
      XOP_COM = 4'h3,
      XOP_NEG = 4'h4,
      XOP_LSL = 4'h5,
      XOP_LSR = 4'h6,
      XOP_ROL = 4'h7,
      XOP_ROR = 4'h8,
      XOP_ASR = 4'h9
   } cprs_xop_t;

   // Address modes for effective address
   typedef enum logic [2:0] {
      AM_DIR = 3'h0,
      AM_EXT = 3'h1,
      AM_IX = 3'h2,
      AM_IX1 = 3'h3,
      AM_IX2 = 3'h4,
      AM_IXP = 3'h5,
      AM_SP1 = 3'h6,
      AM_SP2 = 3'h7
   } cprs_mode_t;

   // Sequencer states
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_PUSH = 2'h1,
      ST_PULL = 2'h2,
      ST_PCAP = 2'h3
   } cprs_state_t;

   // Sign-extend a byte to a 16-bit offset
   function automatic logic [15:0] cprs_sext8(input logic [7:0] v);
      return {{8{v[7]}}, v};
   endfunction

endpackage

// *** core/cprs_alu_if.sv ***
// Operand and result bundle between the register set and its arithmetic unit
`timescale 1ns/1ps
interface cprs_alu_if;
   import cprs_pkg::*;
   logic [7:0] acc;
   logic [7:0] idx_hi;
   logic [7:0] idx_lo;
   logic [15:0] stack_pointer;
   logic [7:0] imm;
   logic [15:0] data;
   logic [15:0] pc;
   logic cin;
   cprs_xop_t xop;
   cprs_mode_t mode;
   logic [7:0] xres;
   logic [15:0] prod;
   logic [7:0] quot;
   logic [7:0] rem;
   logic div_bad;
   logic [15:0] ea;
   logic [15:0] hx_inc;
   logic [15:0] br_target;
   logic [15:0] stack_adjusted;

   modport core (
      output acc, idx_hi, idx_lo, stack_pointer, imm, data, pc, cin,
      output xop, mode,
      input xres, prod, quot, rem, div_bad, ea, hx_inc, br_target,
      input stack_adjusted
   );
   modport alu (
      input acc, idx_hi, idx_lo, stack_pointer, imm, data, pc, cin,
      input xop, mode,
      output xres, prod, quot, rem, div_bad, ea, hx_inc, br_target,
      output stack_adjusted
   );
endinterface

// *** core/cprs_alu.sv ***
// Combinational arithmetic: index byte ops, multiply, divide, addresses
`timescale 1ns/1ps
module cprs_alu (
   cprs_alu_if.alu bus
);
   import cprs_pkg::*;

   logic [15:0] hx;
   logic [15:0] dividend;
   logic [15:0] q16;
   logic [15:0] r16;

   // Second data register operations
   always_comb begin
      hx = {bus.idx_hi, bus.idx_lo};
      unique case (bus.xop)
         XOP_CLR: bus.xres = 8'h00;
         XOP_INC: bus.xres = bus.idx_lo + 8'h01;
         XOP_DEC: bus.xres = bus.idx_lo - 8'h01;
         XOP_COM: bus.xres = ~bus.idx_lo;
         XOP_NEG: bus.xres = 8'h00 - bus.idx_lo;
         XOP_LSL: bus.xres = {bus.idx_lo[6:0], 1'b0};
         XOP_LSR: bus.xres = {1'b0, bus.idx_lo[7:1]};
         XOP_ROL: bus.xres = {bus.idx_lo[6:0], bus.cin};
         XOP_ROR: bus.xres = {bus.cin, bus.idx_lo[7:1]};
         XOP_ASR: bus.xres = {bus.idx_lo[7], bus.idx_lo[7:1]};
         default: bus.xres = bus.idx_lo; // Codes above ASR are illegal
      endcase
   end

   // Multiply and divide; a zero divisor or wide quotient is refused
   always_comb begin
      dividend = {bus.idx_hi, bus.acc};
      bus.prod = {8'h00, bus.acc} * {8'h00, bus.idx_lo};
      q16 = 16'h0000;
      r16 = 16'h0000;
      if (bus.idx_lo != 8'h00) begin
         q16 = dividend / {8'h00, bus.idx_lo};
         r16 = dividend % {8'h00, bus.idx_lo};
      end
      bus.div_bad = (bus.idx_lo == 8'h00) || (q16[15:8] != 8'h00);
      bus.quot = q16[7:0];
      bus.rem = r16[7:0];
   end

   // Effective address; indexed modes always use both index bytes
   always_comb begin
      bus.hx_inc = hx + 16'h0001;
      bus.br_target = bus.pc + cprs_sext8(bus.imm);
      bus.stack_adjusted = bus.stack_pointer + cprs_sext8(bus.imm);
      unique case (bus.mode)
         AM_DIR: bus.ea = {DIR_PAGE, bus.imm};
         AM_EXT: bus.ea = bus.data;
         AM_IX: bus.ea = hx;
         AM_IX1: bus.ea = hx + {8'h00, bus.imm};
         AM_IX2: bus.ea = hx + bus.data;
         AM_IXP: bus.ea = hx;
         AM_SP1: bus.ea = bus.stack_pointer + {8'h00, bus.imm};
         AM_SP2: bus.ea = bus.stack_pointer + bus.data;
      endcase
   end

endmodule // cprs_alu

// *** core/cprs_regs.sv ***
// CPU programmer register set: accumulator, index pair, stack pointer
`timescale 1ns/1ps
module cprs_regs (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic cmd_valid,
   input cprs_pkg::cprs_cmd_t cmd_code,
   input wire logic [3:0] cmd_sub,
   input wire logic [7:0] cmd_imm,
   input wire logic [15:0] cmd_data,
   input wire logic [15:0] cmd_pc,
   input wire logic [7:0] cmd_ccr,
   input wire logic [7:0] mem_rdata,
   output logic cmd_ready,
   output logic [7:0] acc,
   output logic [7:0] idx_hi,
   output logic [7:0] idx_lo,
   output logic [15:0] stack_pointer,
   output logic [15:0] ea,
   output logic [15:0] branch_target,
   output logic div_err,
   output logic [15:0] mem_addr,
   output logic [7:0] mem_wdata,
   output logic mem_we,
   output logic mem_re
);
   import cprs_pkg::*;

   cprs_state_t state;
   cprs_state_t next_state;
   logic [2:0] cnt;
   logic [2:0] next_cnt;
   logic [4:0][7:0] pbuf;
   logic [4:0][7:0] next_pbuf;
   logic next_ready;
   logic [7:0] next_acc;
   logic [7:0] next_idx_hi;
   logic [7:0] next_idx_lo;
   logic [15:0] next_stack_pointer;
   logic [15:0] next_ea;
   logic [15:0] next_bt;
   logic next_div_err;
   logic [15:0] next_mem_addr;
   logic [7:0] next_mem_wdata;
   logic next_mem_we;
   logic next_mem_re;
   logic take;

   cprs_alu_if alu_bus ();

   cprs_alu u_alu (
      .bus(alu_bus.alu)
   );

   // Operands to the arithmetic unit
   assign alu_bus.acc = acc;
   assign alu_bus.idx_hi = idx_hi;
   assign alu_bus.idx_lo = idx_lo;
   assign alu_bus.stack_pointer = stack_pointer;
   assign alu_bus.imm = cmd_imm;
   assign alu_bus.data = cmd_data;
   assign alu_bus.pc = cmd_pc;
   assign alu_bus.cin = cmd_ccr[0];
   assign alu_bus.xop = cprs_xop_t'(cmd_sub);
   assign alu_bus.mode = cprs_mode_t'(cmd_sub[2:0]);

   // Commands are taken only while the sequencer is idle
   assign take = cmd_valid && cmd_ready;

   // Next-state logic for every register of the block
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_pbuf = pbuf;
      next_acc = acc;
      next_idx_hi = idx_hi;
      next_idx_lo = idx_lo;
      next_stack_pointer = stack_pointer;
      next_ea = ea;
      next_bt = branch_target;
      next_div_err = div_err;
      next_mem_addr = mem_addr;
      next_mem_wdata = mem_wdata;
      next_mem_we = 1'b0;
      next_mem_re = 1'b0;
      unique case (state)
         ST_IDLE: begin
            if (take) begin
               unique case (cmd_code)
                  CMD_NOP: begin
                  end
                  CMD_LDA: next_acc = cmd_data[7:0];
                  CMD_LDX: next_idx_lo = cmd_data[7:0];
                  CMD_LDHX: begin
                     next_idx_hi = cmd_data[15:8];
                     next_idx_lo = cmd_data[7:0];
                  end
                  CMD_LDSP: next_stack_pointer = cmd_data;
                  CMD_XOP: next_idx_lo = alu_bus.xres;
                  CMD_MUL: begin
                     next_idx_lo = alu_bus.prod[15:8];
                     next_acc = alu_bus.prod[7:0];
                  end
                  CMD_DIV: begin
                     // A refused divide keeps both operands intact
                     next_div_err = alu_bus.div_bad;
                     if (!alu_bus.div_bad) begin
                        next_acc = alu_bus.quot;
                        next_idx_hi = alu_bus.rem;
                     end
                  end
                  CMD_ADD_IMMEDIATE_TO_STACK: begin
                     next_stack_pointer = alu_bus.stack_adjusted;
                  end
                  CMD_RESET_STACK_LOW: begin
                     // High byte kept; only the low byte is forced
                     next_stack_pointer = {stack_pointer[15:8],
                        RESET_STACK_LOW_BYTE};
                  end
                  CMD_EA: begin
                     next_ea = alu_bus.ea;
                     if (alu_bus.mode == AM_IXP) begin
                        next_idx_hi = alu_bus.hx_inc[15:8];
                        next_idx_lo = alu_bus.hx_inc[7:0];
                     end
                  end
                  CMD_BRA: next_bt = alu_bus.br_target;
                  CMD_PSHA: begin
                     next_pbuf = {32'h0000_0000, acc};
                     next_cnt = ONE_BYTE;
                     next_state = ST_PUSH;
                  end
                  CMD_PULA: begin
                     // Pointer moves before the read
                     next_stack_pointer = stack_pointer + 16'h0001;
                     next_mem_addr = stack_pointer + 16'h0001;
                     next_mem_re = 1'b1;
                     next_state = ST_PULL;
                  end
                  CMD_CALL: begin
                     // Return address, low byte first
                     next_pbuf = {24'h00_0000, cmd_pc};
                     next_cnt = CALL_BYTES;
                     next_state = ST_PUSH;
                  end
                  CMD_INTR: begin
                     // Return address, index low, accumulator, flags
                     next_pbuf = {cmd_ccr, acc, idx_lo, cmd_pc};
                     next_cnt = INTR_BYTES;
                     next_state = ST_PUSH;
                  end
               endcase
            end
         end
         ST_PUSH: begin
            // Write at the free slot, then step down
            next_mem_we = 1'b1;
            next_mem_addr = stack_pointer;
            next_mem_wdata = pbuf[0];
            next_pbuf = {8'h00, pbuf[4:1]};
            next_stack_pointer = stack_pointer - 16'h0001;
            next_cnt = cnt - 3'h1;
            if (cnt == ONE_BYTE) begin
               next_state = ST_IDLE;
            end
         end
         ST_PULL: next_state = ST_PCAP;
         ST_PCAP: begin
            next_acc = mem_rdata;
            next_state = ST_IDLE;
         end
      endcase
      next_ready = (next_state == ST_IDLE);
   end

   // Control registers and pointers with defined reset values
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state <= ST_IDLE;
         cnt <= 3'h0;
         pbuf <= '0;
         cmd_ready <= 1'b0;
         idx_hi <= IDX_HI_RESET;
         stack_pointer <= STACK_RESET;
         ea <= 16'h0000;
         branch_target <= 16'h0000;
         div_err <= 1'b0;
         // Registers live here only; no address decodes onto them
         mem_addr <= 16'h0000;
         mem_wdata <= 8'h00;
         mem_we <= 1'b0;
         mem_re <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         pbuf <= next_pbuf;
         cmd_ready <= next_ready;
         idx_hi <= next_idx_hi;
         stack_pointer <= next_stack_pointer;
         ea <= next_ea;
         branch_target <= next_bt;
         div_err <= next_div_err;
         mem_addr <= next_mem_addr;
         mem_wdata <= next_mem_wdata;
         mem_we <= next_mem_we;
         mem_re <= next_mem_re;
      end
   end

   // Data registers keep their contents through reset
   always_ff @(posedge core_clk) begin
      acc <= next_acc;
      idx_lo <= next_idx_lo;
   end

   // Checks on the register behaviour
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);

   AST_ACC_LOAD: assert property (
      take && cmd_code == CMD_LDA |=> acc == $past(cmd_data[7:0]))
      else $error("accumulator load lost");

   AST_HI_RESET: assert property (
      $rose(resetn) |-> idx_hi == 8'h00 && stack_pointer == 16'h00FF)
      else $error("pointer reset values wrong");

   AST_XOP_HI: assert property (
      take && cmd_code == CMD_XOP |=> $stable(idx_hi))
      else $error("byte operation touched high index");

   AST_STACK_ADD: assert property (
      take && cmd_code == CMD_ADD_IMMEDIATE_TO_STACK |=> stack_pointer ==
      16'($past(stack_pointer) + {{8{$past(cmd_imm[7])}}, $past(cmd_imm)}))
      else $error("stack adjust sum wrong");

   AST_STACK_LOW: assert property (
      take && cmd_code == CMD_RESET_STACK_LOW
      |=> stack_pointer[7:0] == RESET_STACK_LOW_BYTE
      && stack_pointer[15:8] == $past(stack_pointer[15:8]))
      else $error("stack reset changed high byte");

   AST_PUSH_ADDR: assert property (
      mem_we |-> mem_addr == 16'(stack_pointer + 16'h0001))
      else $error("push did not decrement after write");

   AST_INTR_LEN: assert property (
      take && cmd_code == CMD_INTR |=> !mem_we ##1 mem_we [*5] ##1 !mem_we)
      else $error("interrupt stacking length wrong");

   AST_DIR_PAGE: assert property (
      take && cmd_code == CMD_EA && cmd_sub[2:0] == 3'h0
      |=> ea == {8'h00, $past(cmd_imm)})
      else $error("direct address left page zero");

   AST_BRANCH: assert property (
      take && cmd_code == CMD_BRA |=> branch_target ==
      16'($past(cmd_pc) + {{8{$past(cmd_imm[7])}}, $past(cmd_imm)}))
      else $error("branch target wrong");

   AST_IXP_INC: assert property (
      take && cmd_code == CMD_EA && cmd_sub[2:0] == 3'h5
      |=> {idx_hi, idx_lo} == 16'($past({idx_hi, idx_lo}) + 16'h0001)
      && ea == $past({idx_hi, idx_lo}))
      else $error("post increment wrong");

   AST_PULL_ACC: assert property (
      take && cmd_code == CMD_PULA |=> mem_re
      && mem_addr == 16'($past(stack_pointer) + 16'h0001)
      ##1 !mem_re ##1 acc == $past(mem_rdata) && cmd_ready)
      else $error("pull sequence wrong");

   AST_LDX_LOW: assert property (
      take && cmd_code == CMD_LDX
      |=> idx_lo == $past(cmd_data[7:0]) && $stable(idx_hi))
      else $error("low byte load touched high index");

   AST_LDHX_PAIR: assert property (
      take && cmd_code == CMD_LDHX |=> {idx_hi, idx_lo} == $past(cmd_data))
      else $error("index pair load wrong");

   AST_MUL_PROD: assert property (
      take && cmd_code == CMD_MUL |=> {idx_lo, acc} ==
      {8'h00, $past(acc)} * {8'h00, $past(idx_lo)})
      else $error("multiply product wrong");

   // A divide by a zero divisor must leave both dividend bytes in place
   AST_DIV_REFUSE: assert property (
      take && cmd_code == CMD_DIV && idx_lo == 8'h00
      |=> div_err && $stable(acc) && $stable(idx_hi))
      else $error("zero divisor not refused");

   // Commands offered while busy are dropped, so data registers hold during stacking
   AST_BUSY_HOLD: assert property (
      state == ST_PUSH |=> $stable(acc) && $stable(idx_lo))
      else $error("register changed during stacking");

endmodule // cprs_regs

// *** testbench/test_cpu_programmer_register_set.sv ***
// Self-checking bench for the CPU programmer register set
`timescale 1ns/1ps
module test_cpu_programmer_register_set;
   import cprs_pkg::*;
   logic core_clk, resetn, cmd_valid;
   cprs_cmd_t cmd_code;
   logic [3:0] cmd_sub;
   logic [7:0] cmd_imm, cmd_ccr, mem_rdata, acc, idx_hi, idx_lo, mem_wdata;
   logic [15:0] cmd_data, cmd_pc, stack_pointer, ea, branch_target, mem_addr;
   logic cmd_ready, div_err, mem_we, mem_re;
   // Reference registers, stack memory and the notes of expected results
   logic [7:0] m_acc, m_hi, m_lo;
   logic [15:0] m_stk, m_ea, m_bt;
   logic m_de;
   logic [7:0] m_ram [logic [15:0]];
   logic [72:0] sq[$];
   logic [24:0] mq[$];
   int miscompares, samples_checked, k;
   logic [23:0] dv [4] = '{24'h010004, 24'h050004, 24'h123400, 24'h00FFFF};

   cprs_regs DUT (.core_clk, .resetn, .cmd_valid, .cmd_code, .cmd_sub,
      .cmd_imm, .cmd_data, .cmd_pc, .cmd_ccr, .mem_rdata, .cmd_ready, .acc,
      .idx_hi, .idx_lo, .stack_pointer, .ea, .branch_target, .div_err,
      .mem_addr, .mem_wdata, .mem_we, .mem_re);

   // 200 MHz core clock
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   task automatic tally_and_finish();
      $display("checked %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic cmp(input logic [72:0] g, input logic [72:0] e,
                      input string w);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %0t %s got %h exp %h", $time, w, g, e);
      end
   endtask

   // One stacked byte: written at the pointer, then the pointer moves down
   task automatic pushb(input logic [7:0] b);
      m_ram[m_stk] = b;
      mq.push_back({1'b1, m_stk, b});
      m_stk = m_stk - 16'h0001;
   endtask

   // Expected effect of a taken command, noted for the monitors
   task automatic model(input cprs_cmd_t c, input logic [3:0] s,
                        input logic [7:0] i, input logic [15:0] d);
      logic [15:0] hx, q;
      hx = {m_hi, m_lo};
      q = 16'h0000;
      case (c)
         CMD_LDA: m_acc = d[7:0];
         CMD_LDX: m_lo = d[7:0];
         CMD_LDHX: {m_hi, m_lo} = d;
         CMD_LDSP: m_stk = d;
         CMD_XOP: case (s)
            XOP_CLR: m_lo = 8'h00;
            XOP_INC: m_lo = m_lo + 8'h01;
            XOP_DEC: m_lo = m_lo - 8'h01;
            XOP_COM: m_lo = ~m_lo;
            XOP_NEG: m_lo = 8'h00 - m_lo;
            XOP_LSL: m_lo = {m_lo[6:0], 1'b0};
            XOP_LSR: m_lo = {1'b0, m_lo[7:1]};
            XOP_ROL: m_lo = {m_lo[6:0], cmd_ccr[0]};
            XOP_ROR: m_lo = {cmd_ccr[0], m_lo[7:1]};
            XOP_ASR: m_lo = {m_lo[7], m_lo[7:1]};
            default: m_lo = m_lo;
         endcase
         CMD_MUL: {m_lo, m_acc} = m_acc * m_lo;
         CMD_DIV: begin
            if (m_lo != 8'h00) q = {m_hi, m_acc} / m_lo;
            m_de = (m_lo == 8'h00) || (q > 16'h00FF);
            if (!m_de) begin
               m_hi = {m_hi, m_acc} % m_lo;
               m_acc = q[7:0];
            end
         end
         CMD_EA: case (s[2:0])
            AM_DIR: m_ea = {DIR_PAGE, i};
            AM_EXT: m_ea = d;
            AM_IX: m_ea = hx;
            AM_IX1: m_ea = hx + {8'h00, i};
            AM_IX2: m_ea = hx + d;
            AM_IXP: begin
               m_ea = hx;
               {m_hi, m_lo} = hx + 16'h0001;
            end
            AM_SP1: m_ea = m_stk + {8'h00, i};
            default: m_ea = m_stk + d;
         endcase
         CMD_ADD_IMMEDIATE_TO_STACK: m_stk = m_stk + {{8{i[7]}}, i};
         CMD_RESET_STACK_LOW: m_stk[7:0] = RESET_STACK_LOW_BYTE;
         CMD_BRA: m_bt = cmd_pc + {{8{i[7]}}, i};
         CMD_PSHA: pushb(m_acc);
         CMD_PULA: begin
            m_stk = m_stk + 16'h0001;
            mq.push_back({1'b0, m_stk, 8'h00});
            m_acc = m_ram[m_stk];
         end
         CMD_CALL: begin
            pushb(cmd_pc[7:0]);
            pushb(cmd_pc[15:8]);
         end
         CMD_INTR: begin
            pushb(cmd_pc[7:0]);
            pushb(cmd_pc[15:8]);
            pushb(m_lo);
            pushb(m_acc);
            pushb(cmd_ccr);
         end
         default: m_acc = m_acc;
      endcase
      sq.push_back({m_acc, m_hi, m_lo, m_stk, m_ea, m_bt, m_de});
   endtask

   // Present a command and hold it until taken; valid stays up after
   task automatic run(input cprs_cmd_t c, input logic [3:0] s,
                      input logic [7:0] i, input logic [15:0] d);
      int n;
      cmd_valid = 1'b1;
      cmd_code = c;
      cmd_sub = s;
      cmd_imm = i;
      cmd_data = d;
      cmd_pc = 16'($urandom);
      cmd_ccr = 8'($urandom);
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (cmd_ready !== 1'b1 && n < 40);
      if (n >= 40) begin
         $display("[ERR] %0t command never taken", $time);
         miscompares++;
         tally_and_finish();
      end
      model(c, s, i, d);
      #1;
      // Stray load while busy: must be dropped, not queued
      if (c inside {CMD_PSHA, CMD_PULA, CMD_CALL, CMD_INTR}) begin
         cmd_code = CMD_LDA;
         cmd_data = ~d;
         @(posedge core_clk);
         #1;
      end
   endtask

   task automatic do_reset();
      cmd_valid = 1'b0;
      @(posedge core_clk);
      #1;
      resetn = 1'b0;
      m_hi = IDX_HI_RESET;
      m_stk = STACK_RESET;
      m_ea = 16'h0000;
      m_bt = 16'h0000;
      m_de = 1'b0;
      repeat (6) @(posedge core_clk);
      #1;
      resetn = 1'b1;
      @(posedge core_clk);
      #1;
   endtask

   // Register monitor: a take is judged when cmd_ready is back high
   initial begin : reg_mon
      int w;
      forever begin
         @(posedge core_clk);
         if (resetn === 1'b1 && cmd_valid === 1'b1 && cmd_ready === 1'b1) begin
            @(negedge core_clk);
            for (w = 0; w < 20 && cmd_ready !== 1'b1; w++) @(negedge core_clk);
            if (w == 20 || sq.size() == 0) begin
               $display("[ERR] %0t result never settled", $time);
               miscompares++;
               tally_and_finish();
            end
            cmp({acc, idx_hi, idx_lo, stack_pointer, ea, branch_target,
                 div_err}, sq.pop_front(), "regs");
         end
      end
   end

   // Memory monitor: each stacked or pulled byte against the oldest note
   always @(negedge core_clk) begin
      logic [24:0] e;
      if (mem_we === 1'b1 || mem_re === 1'b1) begin
         e = (mq.size() > 0) ? mq.pop_front() : 'x;
         cmp(73'({mem_we, mem_addr, mem_we === 1'b1 ? mem_wdata : 8'h00}),
             73'(e), "mem");
      end
   end

   // Read data only valid the cycle after a pull; otherwise noise
   initial begin : feeder
      logic r;
      logic [15:0] a;
      mem_rdata = 8'h00;
      forever begin
         @(posedge core_clk);
         r = mem_re;
         a = mem_addr;
         #1;
         mem_rdata = (r === 1'b1 && m_ram.exists(a)) ? m_ram[a] : 8'($urandom);
      end
   end

   // Main sequence
   initial begin
      void'($urandom(26975));
      {resetn, cmd_valid, cmd_sub, cmd_imm, cmd_data, cmd_pc, cmd_ccr} = '0;
      cmd_code = CMD_NOP;
      {m_acc, m_lo} = 'x;
      do_reset();
      cmp(73'({idx_hi, stack_pointer, ea, branch_target, div_err}),
          73'({IDX_HI_RESET, STACK_RESET, 33'h0}), "reset");
      run(CMD_LDA, 4'h0, 8'h00, 16'($urandom));
      run(CMD_LDHX, 4'h0, 8'h00, 16'($urandom));
      run(CMD_NOP, 4'h0, 8'($urandom), 16'($urandom));
      for (k = 0; k < 16; k++) begin
         run(CMD_LDX, 4'h0, 8'h00, 16'($urandom));
         run(CMD_XOP, 4'(k), 8'h00, 16'h0000);
      end
      run(CMD_LDSP, 4'h0, 8'h00, 16'($urandom));
      for (k = 0; k < 16; k++) begin
         run(CMD_LDHX, 4'h0, 8'h00, 16'($urandom));
         run(CMD_EA, 4'(k % 8), 8'($urandom), 16'($urandom));
      end
      run(CMD_LDHX, 4'h0, 8'h00, 16'hFFFF);
      run(CMD_EA, 4'(AM_IXP), 8'h00, 16'h0000);
      run(CMD_LDSP, 4'h0, 8'h00, 16'h0000);
      run(CMD_ADD_IMMEDIATE_TO_STACK, 4'h0, 8'h80, 16'h0000);
      run(CMD_ADD_IMMEDIATE_TO_STACK, 4'h0, 8'h7F, 16'h0000);
      run(CMD_ADD_IMMEDIATE_TO_STACK, 4'h0, 8'($urandom), 16'h0000);
      run(CMD_LDSP, 4'h0, 8'h00, 16'h5A00);
      run(CMD_RESET_STACK_LOW, 4'h0, 8'h00, 16'h0000);
      for (k = 0; k < 4; k++) begin
         run(CMD_BRA, 4'h0, 8'($urandom), 16'h0000);
         run(CMD_LDA, 4'h0, 8'h00, 16'($urandom));
         run(CMD_LDX, 4'h0, 8'h00, 16'($urandom));
         run(CMD_MUL, 4'h0, 8'h00, 16'h0000);
         run(CMD_LDHX, 4'h0, 8'h00, {dv[k][23:16], dv[k][7:0]});
         run(CMD_LDA, 4'h0, 8'h00, {8'h00, dv[k][15:8]});
         run(CMD_DIV, 4'h0, 8'h00, 16'h0000);
      end
      run(CMD_LDSP, 4'h0, 8'h00, 16'h0200);
      run(CMD_PSHA, 4'h0, 8'h00, 16'h0000);
      run(CMD_CALL, 4'h0, 8'h00, 16'h0000);
      run(CMD_INTR, 4'h0, 8'h00, 16'h0000);
      for (k = 0; k < 8; k++) run(CMD_PULA, 4'h0, 8'h00, 16'h0000);
      run(CMD_LDHX, 4'h0, 8'h00, 16'($urandom));
      run(CMD_LDA, 4'h0, 8'h00, 16'($urandom));
      do_reset();
      cmp({acc, idx_hi, idx_lo, stack_pointer, ea, branch_target, div_err},
          {m_acc, m_hi, m_lo, m_stk, m_ea, m_bt, m_de}, "rst");
      repeat (4) @(posedge core_clk);
      tally_and_finish();
   end
endmodule // test_cpu_programmer_register_set
